// ---- include/cdc_params.svh ----
// constants of the configuration daisy-chain link: timing, codes, offsets
// assumes a 50 ns system clock; included by the package and both ends
`ifndef CDC_PARAMS_SVH
`define CDC_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CDC_MCLK_NS 50
`define CDC_PROG_MIN_NS 500
`define CDC_PROG_MIN_CYC ((`CDC_PROG_MIN_NS + `CDC_MCLK_NS - 1) / `CDC_MCLK_NS)
`define CDC_LCLK_HALF_CYC 4
// ----------------------------------------
// mode-select codes and frame
// ----------------------------------------
`define CDC_MODE_FLASH_A 3'h2
`define CDC_MODE_FLASH_B 3'h3
`define CDC_MODE_SLAVE_PAR 3'h6
`define CDC_MEM_WORDS 16
`define CDC_ADDR_W 24
`define CDC_CRC_POLY 8'h07
`define CDC_CRC_INIT 8'h00
// ----------------------------------------
// controller registers (byte addresses) and fields
// ----------------------------------------
`define CDC_REG_CTRL 4'h0
`define CDC_REG_STATUS 4'h4
`define CDC_REG_DATA 4'h8
`define CDC_CTRL_PROG 0
`define CDC_CTRL_MODE_LSB 1
`define CDC_CTRL_PUD 4
`define CDC_CTRL_RDWR 5
`define CDC_CTRL_CSI 6
`define CDC_CTRL_RESET 7'h0c
`endif

// ---- include/cdc_pkg.sv ----
// types and helpers shared by both ends of the daisy-chain link
// assumes cdc_params.svh is on the include path
`include "cdc_params.svh"
package cdc_pkg;
   typedef enum logic [1:0] {st_clear, st_load, st_done, st_error} cdc_state_t;
   typedef logic [2:0] cdc_mode_t;

   // one byte step of the msb-first crc
   function automatic logic [7:0] cdc_crc8(input logic [7:0] crc, input logic [7:0] d);
      logic [7:0] c;
      c = crc ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `CDC_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : cdc_crc8

   // parallel-flash master codes
   function automatic logic cdc_is_master(input cdc_mode_t m);
      return (m == `CDC_MODE_FLASH_A) || (m == `CDC_MODE_FLASH_B);
   endfunction : cdc_is_master
endpackage : cdc_pkg

// ---- include/cdc_link_if.sv ----
// pins between a configurable device and its upstream controller
// open-drain pins resolve here with an implied pull-up
`timescale 1ns/1ps
`include "cdc_params.svh"
interface cdc_link_if;
   logic program_request_n;
   logic [2:0] mode_sel;
   logic pullup_disable;
   logic read_write_select_n;
   logic chain_select_in_n;
   logic [7:0] data;
   logic lclk_host;
   logic lclk_dev_o;
   logic lclk_dev_oe;
   logic [`CDC_ADDR_W-1:0] flash_addr;
   logic chain_select_out_n;
   logic init_o;
   logic init_oe;
   logic done_o;
   logic done_oe;
   logic init_n;
   logic done;
   logic config_clock;

   // open-drain wires float high unless pulled low
   assign init_n = init_oe ? init_o : 1'b1;
   assign done = done_oe ? done_o : 1'b1;
   // master-mode device drives the clock, otherwise the controller
   assign config_clock = lclk_dev_oe ? lclk_dev_o : lclk_host;

   modport dev (
      input program_request_n, mode_sel, pullup_disable, read_write_select_n,
      input chain_select_in_n, data, config_clock,
      output lclk_dev_o, lclk_dev_oe, flash_addr, chain_select_out_n,
      output init_o, init_oe, done_o, done_oe
   );
   modport host (
      output program_request_n, mode_sel, pullup_disable, read_write_select_n,
      output chain_select_in_n, data, lclk_host,
      input config_clock, flash_addr, chain_select_out_n, init_n, done
   );
endinterface : cdc_link_if

// ---- src/cdc_dev.sv ----
// configurable device end: clear, mode sample, byte load, check, chain hand-off
// assumes link pins are asynchronous to mclk; all are synchronised first
// How it works
// - flash master strapped with code 010 or 011
// - downstream flash-chain devices strapped slave parallel 110
// - after load, keep addressing and assert chain-select
// - master config clock paces downstream capture
// - hold init low during memory clear
// - release init and sample mode together
// - crc error drives init low
// - done held low until successful load
// - long program-request pulse restarts on rise
// - controller holds program-request high, pulses to reprogram
// - controller keeps mode pins defined at sampling
// - pull-up disable low enables pull-ups, held constant
// - slave chain keeps read-write select low
// - loaded slave asserts chain-select for next device
// - serial chain devices use slave serial mode
`timescale 1ns/1ps
`include "cdc_params.svh"
module cdc_dev import cdc_pkg::*; #(
   parameter int MEM_WORDS = `CDC_MEM_WORDS,
   parameter int CLK_HALF = `CDC_LCLK_HALF_CYC,
   parameter int PROG_MIN = `CDC_PROG_MIN_CYC,
   parameter int AW = $clog2(MEM_WORDS)
) (
   // system
   input wire logic mclk,
   input wire logic reset,
   // link
   cdc_link_if.dev link,
   // user side
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data,
   output logic configured,
   output logic crc_error,
   output logic pullups_on,
   output logic master_mode
);
   localparam int SW = 16;
   localparam int CW = $clog2(CLK_HALF + 1);
   localparam int PW = $clog2(PROG_MIN + 1);

   logic [SW-1:0] sync1, sync2;
   logic prog_s, lclk_s, csi_s, pud_s, rdwr_s;
   cdc_mode_t mode_s;
   logic [7:0] data_s;
   logic prog_d, lclk_d, lclk_rise, restart, capture;
   logic [PW-1:0] low_cnt;
   cdc_state_t state;
   logic [AW-1:0] clr_idx;
   logic [AW:0] byte_idx;
   logic [7:0] crc_q;
   logic [7:0] mem [MEM_WORDS];
   logic [CW-1:0] div_cnt;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // two flops on every pin; only sync2 is read
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         // idle levels: clock low, so no false edge follows reset
         sync1 <= 16'hbfff;
         sync2 <= 16'hbfff;
      end else begin
         sync1 <= {link.program_request_n, link.config_clock, link.chain_select_in_n, link.pullup_disable,
                   link.read_write_select_n, link.mode_sel, link.data};
         sync2 <= sync1;
      end
   end
   assign {prog_s, lclk_s, csi_s, pud_s, rdwr_s, mode_s, data_s} = sync2;

   // edge history of the synced clock and program request
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         prog_d <= 1'b1;
         lclk_d <= 1'b0;
      end else begin
         prog_d <= prog_s;
         lclk_d <= lclk_s;
      end
   end
   assign lclk_rise = lclk_s & ~lclk_d;

   // ----------------------------------------
   // restart on program request
   // ----------------------------------------
   // low time saturates so long pulses never wrap
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         low_cnt <= '0;
      end else if (prog_s) begin
         low_cnt <= '0;
      end else if (low_cnt != PW'(PROG_MIN)) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end
   assign restart = prog_s & ~prog_d & (low_cnt == PW'(PROG_MIN));

   assign capture = lclk_rise & (state == st_load) & (master_mode | (~csi_s & ~rdwr_s));

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   // reset acts like a restart: clear first, then load
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= st_clear;
      end else if (restart) begin
         state <= st_clear;
      end else begin
         unique case (state)
            st_clear: begin
               if (clr_idx == AW'(MEM_WORDS - 1)) begin
                  state <= st_load;
               end
            end
            st_load: begin
               if (capture && byte_idx == (AW+1)'(MEM_WORDS)) begin
                  state <= (data_s == crc_q) ? st_done : st_error;
               end
            end
            st_done: state <= st_done;
            st_error: state <= st_error;
         endcase
      end
   end

   // clear index and load index
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clr_idx <= '0;
         byte_idx <= '0;
         crc_q <= `CDC_CRC_INIT;
      end else if (restart || state == st_clear) begin
         clr_idx <= restart ? '0 : clr_idx + 1'b1;
         byte_idx <= '0;
         crc_q <= `CDC_CRC_INIT;
      end else if (capture && byte_idx != (AW+1)'(MEM_WORDS)) begin
         byte_idx <= byte_idx + 1'b1;
         crc_q <= cdc_crc8(crc_q, data_s);
      end
   end

   // configuration memory: cleared word by word, then filled
   always_ff @(posedge mclk) begin
      if (state == st_clear) begin
         mem[clr_idx] <= 8'h00;
      end else if (capture && byte_idx != (AW+1)'(MEM_WORDS)) begin
         mem[byte_idx[AW-1:0]] <= data_s;
      end
   end

   // user read port, one cycle latency
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

   // mode latched as init is released
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         master_mode <= 1'b0;
      end else if (restart) begin
         master_mode <= 1'b0;
      end else if (state == st_clear && clr_idx == AW'(MEM_WORDS - 1)) begin
         master_mode <= cdc_is_master(mode_s);
      end
   end

   // ----------------------------------------
   // master clock and flash address
   // ----------------------------------------
   // divider drives the shared config clock
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         div_cnt <= '0;
         link.lclk_dev_o <= 1'b0;
      end else if (!master_mode) begin
         div_cnt <= '0;
         link.lclk_dev_o <= 1'b0;
      end else if (div_cnt == CW'(CLK_HALF - 1)) begin
         div_cnt <= '0;
         link.lclk_dev_o <= ~link.lclk_dev_o;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign link.lclk_dev_oe = master_mode;

   // address keeps stepping after own load
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         link.flash_addr <= '0;
      end else if (restart) begin
         link.flash_addr <= '0;
      end else if (master_mode && link.lclk_dev_o && div_cnt == CW'(CLK_HALF - 1)) begin
         link.flash_addr <= link.flash_addr + 1'b1;
      end
   end

   // ----------------------------------------
   // indicator pins and status
   // ----------------------------------------
   // open-drain pins only ever drive low
   assign link.init_o = 1'b0;
   assign link.done_o = 1'b0;
   // init low again on check failure
   assign link.init_oe = (state == st_clear) | (state == st_error);
   assign link.done_oe = (state != st_done);

   // registered status and chain hand-off
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         link.chain_select_out_n <= 1'b1;
         configured <= 1'b0;
         crc_error <= 1'b0;
         pullups_on <= 1'b0;
      end else begin
         link.chain_select_out_n <= (state != st_done) | restart;
         configured <= (state == st_done) & ~restart;
         crc_error <= (state == st_error) & ~restart;
         // pull-ups follow the pin during configuration
         pullups_on <= ~pud_s & (state != st_done);
      end
   end
endmodule : cdc_dev

// ---- src/cdc_host.sv ----
// upstream controller end plus its byte fifo; software reaches it over AXI4-Lite
// assumes axi runs on mclk and link pins are asynchronous to it
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cdc_params.svh"
// ----------------------------------------
// byte fifo
// ----------------------------------------
// depth must be a power of two; pointers carry one wrap bit
module cdc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   // system
   input wire logic mclk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr;

   assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data = mem[rd_ptr[AW-1:0]];

   // storage
   always_ff @(posedge mclk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   // pointers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(in_valid && in_ready);
         rd_ptr <= rd_ptr + (AW+1)'(out_valid && out_ready);
      end
   end
endmodule : cdc_fifo

module cdc_host import cdc_pkg::*; #(
   parameter int PROG_LOW = `CDC_PROG_MIN_CYC,
   parameter int CLK_HALF = `CDC_LCLK_HALF_CYC,
   parameter int DEPTH = 8
) (
   // system
   input wire logic mclk,
   input wire logic reset,
   // axi4-lite write
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link
   cdc_link_if.host link
);
   localparam int PW = $clog2(PROG_LOW + 1);
   localparam int CW = $clog2(CLK_HALF + 1);

   logic [6:0] ctrl;
   logic [3:0] sync1, sync2;
   logic init_s, done_s, cso_s, lclk_s, lclk_d;
   logic [PW-1:0] prog_cnt;
   logic prog_busy, loading, wr_take, wr_data, fifo_in_ready, fifo_out_valid, have;
   logic [7:0] fifo_out_data;
   logic [CW-1:0] half_cnt;

   // ----------------------------------------
   // register slave
   // ----------------------------------------
   // a data write stalls while the fifo is full
   assign wr_data = (s_axi_awaddr == `CDC_REG_DATA);
   assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & (~wr_data | fifo_in_ready);
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = ~s_axi_rvalid;
   assign loading = init_s & ~done_s;

   // write response
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_take) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_data || s_axi_awaddr == `CDC_REG_CTRL) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // strap fields frozen while busy or loading
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl <= `CDC_CTRL_RESET;
      end else if (wr_take && s_axi_awaddr == `CDC_REG_CTRL && s_axi_wstrb[0] && !prog_busy && !loading) begin
         ctrl <= {s_axi_wdata[6:1], 1'b0};
      end
   end

   // read response
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         unique case (s_axi_araddr)
            `CDC_REG_CTRL: s_axi_rdata <= {25'h0, ctrl};
            `CDC_REG_STATUS: s_axi_rdata <= {26'h0, ~fifo_out_valid & ~have, prog_busy, cso_s, done_s, init_s, 1'b0};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // link side
   // ----------------------------------------
   // two flops on every pin read back
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         // pin levels during reset: chain select idles high
         sync1 <= 4'h2;
         sync2 <= 4'h2;
         lclk_d <= 1'b0;
      end else begin
         sync1 <= {link.init_n, link.done, link.chain_select_out_n, link.config_clock};
         sync2 <= sync1;
         lclk_d <= lclk_s;
      end
   end
   assign {init_s, done_s, cso_s, lclk_s} = sync2;

   // request held high, pulsed low on demand
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         prog_cnt <= '0;
      end else if (prog_busy) begin
         prog_cnt <= prog_cnt - 1'b1;
      end else if (wr_take && s_axi_awaddr == `CDC_REG_CTRL && s_axi_wstrb[0] && s_axi_wdata[`CDC_CTRL_PROG]) begin
         prog_cnt <= PW'(PROG_LOW);
      end
   end
   assign prog_busy = (prog_cnt != '0);
   assign link.program_request_n = ~prog_busy;
   assign link.mode_sel = ctrl[`CDC_CTRL_MODE_LSB +: 3];
   assign link.pullup_disable = ctrl[`CDC_CTRL_PUD];
   // write direction kept low by default
   assign link.read_write_select_n = ctrl[`CDC_CTRL_RDWR];
   assign link.chain_select_in_n = ctrl[`CDC_CTRL_CSI];

   cdc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .in_valid(wr_take & wr_data & s_axi_wstrb[0]),
      .in_data(s_axi_wdata[7:0]),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(~have)
   );

   // byte on the pins: loaded from fifo, retired after a clock rise
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         have <= 1'b0;
         link.data <= 8'h00;
      end else if (!have && fifo_out_valid) begin
         have <= 1'b1;
         link.data <= fifo_out_data;
      end else if (have && cdc_is_master(link.mode_sel) && lclk_s && !lclk_d) begin
         have <= 1'b0;
      end else if (have && link.lclk_host && half_cnt == CW'(CLK_HALF - 1)) begin
         have <= 1'b0;
      end
   end

   // slave-mode clock: a half period of setup, then high, then low
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         half_cnt <= '0;
         link.lclk_host <= 1'b0;
      end else if (!have || !init_s || cdc_is_master(link.mode_sel)) begin
         half_cnt <= '0;
         link.lclk_host <= 1'b0;
      end else if (half_cnt == CW'(CLK_HALF - 1)) begin
         half_cnt <= '0;
         link.lclk_host <= ~link.lclk_host;
      end else begin
         half_cnt <= half_cnt + 1'b1;
      end
   end
endmodule : cdc_host

// ---- tb/cdc_link_checker.sv ----
// link pin checker: restart, clear, mode sample, hand-off, master clock
// assumes it sits beside cdc_link_if, on mclk, reset active high
`timescale 1ns/1ps
`include "cdc_params.svh"
module cdc_link_checker (
   // system
   input wire logic mclk,
   input wire logic reset,
   // link
   input wire logic program_request_n,
   input wire logic [2:0] mode_sel,
   input wire logic lclk_dev_o,
   input wire logic lclk_dev_oe,
   input wire logic [`CDC_ADDR_W-1:0] flash_addr,
   input wire logic chain_select_out_n,
   input wire logic init_n,
   input wire logic done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic [4:0] low_cnt;
   // cycles the request pin has been low; saturates so long pulses stay valid
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) low_cnt <= 5'h0;
      else if (program_request_n) low_cnt <= 5'h0;
      else if (low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h1;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   restart_on_rise_a:
      assert property ($rose(program_request_n) && low_cnt >= 5'd10 |-> ##[1:8] (!init_n && !done))
      else $error("no restart after long request pulse");
   done_steady_a:
      assert property (!program_request_n && done |=> done) else $error("done dropped while request low");
   clear_length_a:
      assert property ($rose(init_n) |-> !$past(init_n, 16)) else $error("init released before clear ended");
   mode_sample_a:
      assert property ($rose(init_n) |-> ##[0:2] (lclk_dev_oe == (mode_sel == `CDC_MODE_FLASH_A
         || mode_sel == `CDC_MODE_FLASH_B))) else $error("mode not sampled at init release");
   done_then_select_a:
      assert property ($rose(done) |-> init_n ##[0:1] !chain_select_out_n) else $error("done without hand-off");
   select_needs_done_a:
      assert property ($fell(chain_select_out_n) |-> done) else $error("chain select before done");
   addr_step_a:
      assert property ($changed(flash_addr) |-> flash_addr == $past(flash_addr) + 1'b1 || flash_addr == '0)
      else $error("flash address jumped");
   addr_on_fall_a:
      assert property ($fell(lclk_dev_o) && lclk_dev_oe |-> ##[0:1] $changed(flash_addr))
      else $error("address not stepped on clock fall");
   clock_pace_a:
      assert property ($changed(lclk_dev_o) && lclk_dev_oe |=> ($stable(lclk_dev_o) || !lclk_dev_oe) [*3]
         ##1 ($changed(lclk_dev_o) || !lclk_dev_oe)) else $error("master clock half period wrong");
   // main scenarios
   load_done_c: cover property ($rose(done));
   hand_off_c: cover property ($fell(chain_select_out_n));
   master_c: cover property ($rose(lclk_dev_oe));
endmodule : cdc_link_checker

// ---- tb/config_daisy_chain_control_tb.sv ----
// bench: controller and device joined by the link, driven over axi4-lite
// assumes the design files and cdc_params.svh are compiled first
`timescale 1ns/1ps
`include "cdc_params.svh"
module config_daisy_chain_control_tb;
   logic mclk, reset;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, rd_addr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] rd_data;
   logic [7:0] exp_mem [16];
   logic [23:0] fa;
   logic configured, crc_error, pullups_on, master_mode;
   int n_mismatch, n_checks;
   cdc_link_if link();
   cdc_dev u_cdc_dev (.mclk(mclk), .reset(reset), .link(link.dev), .rd_addr(rd_addr), .rd_data(rd_data),
      .configured(configured), .crc_error(crc_error), .pullups_on(pullups_on), .master_mode(master_mode));
   cdc_host u_cdc_host (.mclk(mclk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link(link.host));
   cdc_link_checker u_chk (.mclk(mclk), .reset(reset), .program_request_n(link.program_request_n),
      .mode_sel(link.mode_sel), .lclk_dev_o(link.lclk_dev_o), .lclk_dev_oe(link.lclk_dev_oe),
      .flash_addr(link.flash_addr), .chain_select_out_n(link.chain_select_out_n), .init_n(link.init_n),
      .done(link.done));
   // ----------------------------------------
   // clock, tasks
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // aw and w offered together; bready stays high so bvalid is taken at once
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge mclk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_bvalid);
      chk(32'(s_axi_bresp), 32'(er));
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axi_rd
   // poll one status bit; the watchdog bounds a hang
   task automatic wait_st(input int b, input logic v);
      do axi_rd(`CDC_REG_STATUS); while (d[b] !== v);
   endtask : wait_st
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
      return x;
   endfunction : crc_step
   // sixteen bytes then check byte; flip corrupts the check byte
   task automatic send_frame(input logic [7:0] base, input logic [7:0] flip);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 16; i++) begin
         exp_mem[i] = base + 8'(i * 5);
         c = crc_step(c, exp_mem[i]);
         axi_wr(`CDC_REG_DATA, {24'h0, exp_mem[i]}, 2'b00);
      end
      axi_wr(`CDC_REG_DATA, {24'h0, c ^ flip}, 2'b00);
   endtask : send_frame
   task automatic chk_mem;
      for (int i = 0; i < 16; i++) begin
         rd_addr <= 4'(i);
         @(posedge mclk);
         @(posedge mclk);
         chk(32'(rd_data), 32'(exp_mem[i]));
      end
   endtask : chk_mem
   task automatic do_reset;
      reset <= 1'b1;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
   endtask : do_reset
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_addr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      s_axi_wstrb = 4'hf;
      reset = 1'b1;
      do_reset();
      chk(32'(link.init_n), 32'h0);
      axi_rd(`CDC_REG_CTRL);
      chk(d, 32'h0c);
      axi_rd(4'hc);
      chk(32'(r), 32'h2);
      axi_wr(4'hc, 32'h0, 2'b10);
      wait_st(1, 1'b1);
      chk(32'(d[5:1]), 32'h15);
      chk(32'(pullups_on), 32'h1);
      send_frame(8'h21, 8'h01);
      wait_st(1, 1'b0);
      chk(32'({crc_error, configured, link.done}), 32'h4);
      axi_wr(`CDC_REG_CTRL, 32'h0d, 2'b00);
      wait_st(1, 1'b1);
      chk(32'(crc_error), 32'h0);
      send_frame(8'h40, 8'h00);
      wait_st(2, 1'b1);
      chk(32'({configured, link.chain_select_out_n}), 32'h2);
      chk_mem();
      axi_wr(`CDC_REG_CTRL, 32'h05, 2'b00);
      send_frame(8'h90, 8'h00);
      wait_st(2, 1'b1);
      chk(32'({master_mode, link.chain_select_out_n}), 32'h2);
      chk_mem();
      fa = link.flash_addr;
      repeat (40) @(posedge mclk);
      chk(32'(link.flash_addr - fa), 32'h5);
      axi_wr(`CDC_REG_CTRL, 32'h07, 2'b00);
      wait_st(2, 1'b0);
      wait_st(1, 1'b1);
      chk(32'(master_mode), 32'h1);
      // second reset: select held off and pull-ups disabled during clear
      do_reset();
      axi_wr(`CDC_REG_CTRL, 32'h5c, 2'b00);
      wait_st(1, 1'b1);
      chk(32'(pullups_on), 32'h0);
      send_frame(8'h55, 8'h00);
      wait_st(5, 1'b1);
      repeat (20) @(posedge mclk);
      chk(32'({configured, link.done}), 32'h0);
      close_out();
   end
   // watchdog well beyond the expected thousand or so cycles
   initial begin
      repeat (40000) @(posedge mclk);
      n_mismatch++;
      close_out();
   end
endmodule : config_daisy_chain_control_tb
